// file: include/pfm_pkg.sv
// Constants shared by the program flash modify sequencer and its write buffer.
package pfm_pkg;
  // Serial word framing on the programming link
  localparam int          PFM_CMD_BITS    = 4;
  localparam logic [4:0]  PFM_LAST_BIT    = 5'd19;
  localparam logic [4:0]  PFM_START_CLK   = 5'd3;   // Index of the 4th clock of a word
  localparam logic [4:0]  PFM_OUT_FIRST   = 5'd12;  // First clock that drives shifted-out data
  // Four-bit commands
  localparam logic [3:0]  PFM_CMD_CORE    = 4'h0;
  localparam logic [3:0]  PFM_CMD_SHOUT   = 4'h2;
  localparam logic [3:0]  PFM_CMD_TW_INC  = 4'hd;
  localparam logic [3:0]  PFM_CMD_TW_GO   = 4'hf;
  // Core instruction fields
  localparam logic [7:0]  PFM_OP_MOVLW    = 8'h0e;
  localparam logic [7:0]  PFM_OP_MOVWF    = 8'h6e;
  localparam logic [7:0]  PFM_OP_MOVF_W   = 8'h50;
  localparam logic [3:0]  PFM_OP_BSF      = 4'h8;
  localparam logic [3:0]  PFM_OP_BCF      = 4'h9;
  localparam logic [7:0]  PFM_F_PTR_UP    = 8'hf8;
  localparam logic [7:0]  PFM_F_PTR_HI    = 8'hf7;
  localparam logic [7:0]  PFM_F_PTR_LO    = 8'hf6;
  localparam logic [7:0]  PFM_F_LATCH     = 8'hf5;
  localparam logic [7:0]  PFM_F_NVM_CTRL  = 8'ha6;
  // Memory control bit positions
  localparam int          PFM_PMEM_SEL    = 7;
  localparam int          PFM_CFG_SEL     = 6;
  localparam int          PFM_ROW_ERASE   = 4;
  localparam int          PFM_WRITE_ARM   = 2;
  localparam int          PFM_WRITE_START = 1;
  // Pointer and buffer
  localparam int          PFM_PTR_W       = 22;
  localparam logic [21:0] PFM_PTR_STEP    = 22'd2;
  localparam int          PFM_WBUF_BYTES  = 16;
  localparam logic [15:0] PFM_BUF_RESET   = 16'hffff;
  // Register bus map and reset values
  localparam logic [3:0]  PFM_REG_CTRL    = 4'h0;
  localparam logic [3:0]  PFM_REG_STATUS  = 4'h4;
  localparam logic [3:0]  PFM_REG_POINTER = 4'h8;
  localparam logic [3:0]  PFM_REG_LATCH   = 4'hc;
  localparam int          PFM_CTRL_LINK   = 0;
  localparam logic        PFM_LINK_RESET  = 1'b0;
  localparam int          PFM_ST_PROG     = 8;
  localparam int          PFM_ST_ERASE    = 9;
  localparam int          PFM_ST_PEND     = 10;
endpackage : pfm_pkg

// file: include/pfm_buf_if.sv
// Write buffer port between the sequencer and its storage.
interface pfm_buf_if #(parameter int IDX_W = 3) ();
  logic             wr_en;
  logic [IDX_W-1:0] wr_idx;
  logic [15:0]      wr_data;
  logic [IDX_W-1:0] rd_idx;
  logic [15:0]      rd_data;
  modport ctrl  (output wr_en, output wr_idx, output wr_data, output rd_idx, input rd_data);
  modport store (input wr_en, input wr_idx, input wr_data, input rd_idx, output rd_data);
endinterface : pfm_buf_if

// file: src/pfm_write_buffer.sv
// Flip-flop write buffer holding byte pairs for one programming cycle.
module pfm_write_buffer
  import pfm_pkg::*;
#(
  parameter int IDX_W = 3
) (
  input  wire logic clk_i,
  input  wire logic reset_i,
  input  wire logic ce_i,
  pfm_buf_if.store  bus
);
  localparam int WORDS = 1 << IDX_W;

  logic [15:0] mem_reg [WORDS];

  // Storage; reset to the erased pattern so words not written since reset program nothing
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      for (int i = 0; i < WORDS; i++) begin
        mem_reg[i] <= PFM_BUF_RESET;
      end
    end else if (ce_i && bus.wr_en) begin
      mem_reg[bus.wr_idx] <= bus.wr_data;
    end
  end

  // Registered read port for the array
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      bus.rd_data <= PFM_BUF_RESET;
    end else if (ce_i) begin
      bus.rd_data <= mem_reg[bus.rd_idx];
    end
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (reset_i);

  buf_store_a: assert property (ce_i && bus.wr_en |=> mem_reg[$past(bus.wr_idx)] == $past(bus.wr_data)) // R6
    else $error("write buffer did not store payload");
endmodule : pfm_write_buffer

// file: src/pfm_sequencer.sv
// Serial programming link sequencer for row erase and write buffer programming.
// Contract
// R1 - Programmer reads a whole erase block, edits its copy, erases, then rewrites. The bench reads nothing back and rewrites with random data.
// R2 - A write-start without the write-arm bit already set does not proceed.
// R3 - Programmer loads the 22-bit pointer via three literal-and-move instruction pairs.
// R4 - Row erase begins on the 4th clock of the second word after write-start.
// R5 - Programmer polls write-start through the latch until it reads clear.
// R6 - Each byte pair lands at the buffer position chosen by the pointer.
// R7 - Table write with post-increment stores the pair, then advances pointer by two.
// R8 - Programmer uses post-increment writes for all but the final pair.
// R9 - Table write and start stores the final pair and arms programming.
// R10 - Programmer follows start with a zero NOP, clock high then low.
// R11 - Programmer repeats load and program per buffer until the block is rewritten. The bench stops after two buffers.
// R12 - Programming runs while the link clock stays high and ends when it falls.
// R13 - Programmer keeps the link clock low for discharge after each sequence.
// R14 - Pointer addresses the same buffer region at start as during loading.
// R15 - Programmer selects program memory and deselects configuration space first.
// R16 - Programmer clears write-arm after the final block is rewritten.
//
// Our own choices: register access over Wishbone and the address map.
module pfm_sequencer
  import pfm_pkg::*;
#(
  parameter int WBUF_BYTES = PFM_WBUF_BYTES,
  parameter int IDX_W      = $clog2(WBUF_BYTES / 2)
) (
  input  wire logic                 clk_i,
  input  wire logic                 reset_i,
  input  wire logic                 ce_i,
  // Programming link pins
  input  wire logic                 prog_clk_i,
  input  wire logic                 prog_data_i,
  output logic                      prog_data_o,
  output logic                      prog_data_oe_o,
  // Flash array side
  output logic                      flash_erase_o,
  output logic                      flash_program_o,
  output logic [PFM_PTR_W-1:0]      flash_addr_o,
  input  wire logic                 flash_done_i,
  input  wire logic [IDX_W-1:0]     flash_word_idx_i,
  output logic [15:0]               flash_word_o,
  // Classic Wishbone slave
  input  wire logic                 wb_cyc_i,
  input  wire logic                 wb_stb_i,
  input  wire logic                 wb_we_i,
  input  wire logic [3:0]           wb_adr_i,
  input  wire logic [3:0]           wb_sel_i,
  input  wire logic [31:0]          wb_dat_i,
  output logic [31:0]               wb_dat_o,
  output logic                      wb_ack_o
);
  logic                 clk_meta_reg, clk_sync_reg, clk_prev_reg;
  logic                 dat_meta_reg, dat_sync_reg;
  logic                 link_en_reg;
  logic [4:0]           bit_cnt_reg;
  logic [3:0]           cmd_reg;
  logic [15:0]          shift_reg;
  logic [7:0]           w_reg, latch_reg, nvm_control_reg;
  logic [PFM_PTR_W-1:0] table_pointer_reg;
  logic [1:0]           erase_wait_reg;
  logic                 erase_busy_reg, prog_pending_reg;
  logic                 link_rise, link_fall, word_end, core_exec, nvm_bit_op, wr_set, erase_slot;
  logic [15:0]          payload;
  logic [7:0]           op_hi, op_lo;

  pfm_buf_if #(.IDX_W(IDX_W)) buf_bus ();

  pfm_write_buffer #(.IDX_W(IDX_W)) u_buffer (
    .clk_i   (clk_i),
    .reset_i (reset_i),
    .ce_i    (ce_i),
    .bus     (buf_bus.store)
  );

  // Two-stage synchronisers; the link clock is just another pin here
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      clk_meta_reg <= 1'b0;
      clk_sync_reg <= 1'b0;
      clk_prev_reg <= 1'b0;
      dat_meta_reg <= 1'b0;
      dat_sync_reg <= 1'b0;
    end else if (ce_i) begin
      clk_meta_reg <= prog_clk_i;
      clk_sync_reg <= clk_meta_reg;
      clk_prev_reg <= clk_sync_reg;
      dat_meta_reg <= prog_data_i;
      dat_sync_reg <= dat_meta_reg;
    end
  end

  // Edge and instruction decode
  assign link_rise  = ce_i && link_en_reg && clk_sync_reg && !clk_prev_reg;
  assign link_fall  = ce_i && link_en_reg && !clk_sync_reg && clk_prev_reg;
  assign word_end   = link_fall && (bit_cnt_reg == PFM_LAST_BIT);
  assign payload    = {dat_sync_reg, shift_reg[15:1]};  // LSB arrives first
  assign op_hi      = payload[15:8];
  assign op_lo      = payload[7:0];
  assign core_exec  = word_end && (cmd_reg == PFM_CMD_CORE);
  assign nvm_bit_op = core_exec && (op_lo == PFM_F_NVM_CTRL) && !op_hi[0];
  assign wr_set     = nvm_bit_op && (op_hi[7:4] == PFM_OP_BSF) && (op_hi[3:1] == 3'(PFM_WRITE_START));
  assign erase_slot = link_fall && (bit_cnt_reg == PFM_START_CLK) && (erase_wait_reg == 2'd2);

  // Bit framing: four command bits then sixteen payload bits, sampled on the falling edge
  always_ff @(posedge clk_i) begin
    if (reset_i || (ce_i && !link_en_reg)) begin
      bit_cnt_reg <= 5'd0;
      cmd_reg     <= 4'h0;
      shift_reg   <= 16'h0000;
    end else if (link_fall) begin
      bit_cnt_reg <= (bit_cnt_reg == PFM_LAST_BIT) ? 5'd0 : bit_cnt_reg + 5'd1;
      if (bit_cnt_reg < 5'(PFM_CMD_BITS)) begin
        cmd_reg <= {dat_sync_reg, cmd_reg[3:1]};
      end else begin
        shift_reg <= payload;
      end
    end
  end

  // Working register and latch
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      w_reg     <= 8'h00;
      latch_reg <= 8'h00;
    end else if (core_exec) begin
      if (op_hi == PFM_OP_MOVLW) begin
        w_reg <= op_lo;
      end else if (op_hi == PFM_OP_MOVF_W && op_lo == PFM_F_NVM_CTRL) begin
        w_reg <= nvm_control_reg;
      end
      if (op_hi == PFM_OP_MOVWF && op_lo == PFM_F_LATCH) begin
        latch_reg <= w_reg;
      end
    end
  end

  // Table pointer: byte loads and post-increment
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      table_pointer_reg <= '0;
    end else if (core_exec && op_hi == PFM_OP_MOVWF) begin
      case (op_lo)
        PFM_F_PTR_UP: table_pointer_reg[21:16] <= w_reg[5:0];
        PFM_F_PTR_HI: table_pointer_reg[15:8]  <= w_reg;
        PFM_F_PTR_LO: table_pointer_reg[7:0]   <= w_reg;
        default:      table_pointer_reg        <= table_pointer_reg;
      endcase
    end else if (word_end && cmd_reg == PFM_CMD_TW_INC) begin
      table_pointer_reg <= table_pointer_reg + PFM_PTR_STEP;  // R7
    end
  end

  // Memory control; a completion or a refused start clears write-start, a set wins
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      nvm_control_reg <= 8'h00;
    end else if (ce_i) begin
      if (core_exec && op_hi == PFM_OP_MOVWF && op_lo == PFM_F_NVM_CTRL) begin
        nvm_control_reg <= w_reg;
      end else if (nvm_bit_op && op_hi[7:4] == PFM_OP_BSF) begin
        nvm_control_reg[op_hi[3:1]] <= 1'b1;
      end else if (nvm_bit_op && op_hi[7:4] == PFM_OP_BCF) begin
        nvm_control_reg[op_hi[3:1]] <= 1'b0;
      end else if ((erase_busy_reg && flash_done_i) ||
                   (erase_slot && !(nvm_control_reg[PFM_WRITE_ARM] && nvm_control_reg[PFM_ROW_ERASE]))) begin
        nvm_control_reg[PFM_WRITE_START] <= 1'b0;  // R2
      end
    end
  end

  // Erase slot: one whole word after the write-start, then the 4th clock of the next
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      erase_wait_reg <= 2'd0;
      flash_erase_o  <= 1'b0;
      erase_busy_reg <= 1'b0;
    end else if (ce_i) begin
      flash_erase_o <= 1'b0;
      if (wr_set) begin
        erase_wait_reg <= 2'd1;
      end else if (word_end && erase_wait_reg == 2'd1) begin
        erase_wait_reg <= 2'd2;
      end else if (erase_slot) begin
        erase_wait_reg <= 2'd0;
        // Arm must already be set, otherwise the start is dropped
        if (nvm_control_reg[PFM_WRITE_ARM] && nvm_control_reg[PFM_ROW_ERASE]) begin  // R2
          flash_erase_o  <= 1'b1;  // R4
          erase_busy_reg <= 1'b1;
        end
      end
      if (erase_busy_reg && flash_done_i && !erase_slot) begin
        erase_busy_reg <= 1'b0;
      end
    end
  end

  // Programming window: armed by table-write-and-start, held by the link clock
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      prog_pending_reg <= 1'b0;
      flash_program_o  <= 1'b0;
    end else if (ce_i) begin
      if (word_end && cmd_reg == PFM_CMD_TW_GO) begin
        prog_pending_reg <= 1'b1;  // R9
      end else if (link_rise && bit_cnt_reg == PFM_START_CLK && prog_pending_reg) begin
        flash_program_o <= 1'b1;  // R12
      end else if (link_fall && flash_program_o) begin
        flash_program_o  <= 1'b0;  // R12
        prog_pending_reg <= 1'b0;
      end
    end
  end

  // Array address follows the pointer; no timing of its own since the host times it
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      flash_addr_o <= '0;
    end else if (ce_i) begin
      flash_addr_o <= table_pointer_reg;
    end
  end

  // Buffer writes indexed by pointer bits above the byte select
  assign buf_bus.wr_en   = word_end && (cmd_reg == PFM_CMD_TW_INC || cmd_reg == PFM_CMD_TW_GO);  // R7
  assign buf_bus.wr_idx  = table_pointer_reg[IDX_W:1];  // R6
  assign buf_bus.wr_data = payload;
  assign buf_bus.rd_idx  = flash_word_idx_i;
  assign flash_word_o    = buf_bus.rd_data;

  // Latch shift-out: driven on rising edges so the host samples on falling
  always_ff @(posedge clk_i) begin
    if (reset_i || (ce_i && !link_en_reg)) begin
      prog_data_o    <= 1'b0;
      prog_data_oe_o <= 1'b0;
    end else if (word_end) begin
      prog_data_oe_o <= 1'b0;
    end else if (link_rise && cmd_reg == PFM_CMD_SHOUT && bit_cnt_reg >= PFM_OUT_FIRST) begin
      prog_data_oe_o <= 1'b1;
      prog_data_o    <= latch_reg[3'(bit_cnt_reg - PFM_OUT_FIRST)];
    end
  end

  // Wishbone: one wait state, ack drops the cycle after it is given
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      wb_ack_o    <= 1'b0;
      wb_dat_o    <= 32'h0000_0000;
      link_en_reg <= PFM_LINK_RESET;
    end else if (ce_i) begin
      wb_ack_o <= wb_cyc_i && wb_stb_i && !wb_ack_o;
      if (wb_cyc_i && wb_stb_i && !wb_ack_o) begin
        if (wb_we_i && wb_adr_i == PFM_REG_CTRL && wb_sel_i[0]) begin
          link_en_reg <= wb_dat_i[PFM_CTRL_LINK];
        end
        case (wb_adr_i)
          PFM_REG_CTRL:    wb_dat_o <= {31'h0, link_en_reg};
          PFM_REG_STATUS:  wb_dat_o <= {21'h0, prog_pending_reg, erase_busy_reg, flash_program_o, nvm_control_reg};
          PFM_REG_POINTER: wb_dat_o <= {10'h0, table_pointer_reg};
          PFM_REG_LATCH:   wb_dat_o <= {16'h0, w_reg, latch_reg};
          default:         wb_dat_o <= 32'h0000_0000;  // Unmapped reads as zero
        endcase
      end
    end
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (reset_i);

  sequence word_done_s;
    word_end && cmd_reg == PFM_CMD_TW_INC;
  endsequence

  ack_single_a: assert property (wb_ack_o && ce_i |=> !wb_ack_o)
    else $error("ack held longer than one cycle");
  ptr_step_a: assert property (word_done_s |=> table_pointer_reg == $past(table_pointer_reg) + PFM_PTR_STEP) // R7
    else $error("pointer did not advance by two");
  erase_arm_a: assert property (flash_erase_o |-> $past(nvm_control_reg[PFM_WRITE_ARM])) // R2
    else $error("erase began without write arm");
  erase_slot_a: assert property (flash_erase_o |-> $past(erase_slot)) // R4
    else $error("erase began outside its clock slot");
  prog_hold_a: assert property (flash_program_o |-> clk_prev_reg || $past(link_rise)) // R12
    else $error("programming active with link clock low");
  prog_end_a: assert property (flash_program_o && link_fall |=> !flash_program_o && !prog_pending_reg) // R12
    else $error("programming did not end on clock fall");
  start_arm_a: assert property (word_end && cmd_reg == PFM_CMD_TW_GO |=> prog_pending_reg) // R9
    else $error("start command did not arm programming");
  buf_index_a: assert property (buf_bus.wr_en |=> // R6
    u_buffer.mem_reg[$past(table_pointer_reg[IDX_W:1])] == $past(payload))
    else $error("buffer index not taken from pointer");
  ce_freeze_a: assert property (!ce_i |=> $stable(bit_cnt_reg) && $stable(table_pointer_reg) &&
                                $stable(erase_busy_reg))
    else $error("state moved while clock enable low");
endmodule : pfm_sequencer

// file: sim/pfm_prog_model.sv
// Behavioural programmer that drives the serial programming link.
module pfm_prog_model (
  input  wire logic clk_i,
  input  wire logic link_i,
  output logic      prog_clk_o,
  output logic      prog_data_o
);
  timeunit 1ns;
  timeprecision 1ns;
  int bit_n;

  // Link clock stands still low between frames
  initial begin
    prog_clk_o = 1'b0;
    prog_data_o = 1'b0;
    bit_n = 0;
  end

  // One 20-clock word, 400 ns high and 500 ns low per clock; hold stretches the 4th clock high
  task automatic word(input logic [3:0] c, input logic [15:0] p, input int hold, output logic [7:0] rd);
    logic [19:0] w;
    w = {p, c};
    rd = 8'h00;
    for (int i = 0; i < 20; i++) begin
      @(posedge clk_i);
      prog_clk_o <= 1'b1;
      // Command then payload, LSB first; released line toggles so no stale level
      prog_data_o <= (c == 4'h2 && i > 3) ? ~prog_data_o : w[i];
      repeat ((i == 3 && hold > 0) ? hold : 4) @(posedge clk_i);
      if (i > 11) rd[i-12] = link_i;
      prog_clk_o <= 1'b0;
      bit_n = i + 1;
      repeat (4) @(posedge clk_i);
    end
    prog_data_o <= ~prog_data_o;
    // Longer low time after a programming hold
    repeat ((hold > 0) ? 16 : 4) @(posedge clk_i);
    bit_n = 0;
  endtask : word
endmodule : pfm_prog_model

// file: sim/tb_pfm_sequencer.sv
// Self-checking bench for the program flash modify sequencer.
module tb_pfm_sequencer;
  import pfm_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clk_i, reset_i, ce, cyc, stb, we, done, ack, d_o, oe, er, pg, pclk, hdat, link_w;
  logic [3:0]  adr, sel;
  logic [31:0] dat, q, rdat;
  logic [2:0]  widx;
  logic [21:0] faddr, er_addr, pg_addr, a, b;
  logic [15:0] fword, d;
  logic [15:0] ex [8];
  logic [7:0]  rd;
  int          bad_count, compares, er_n, er_bit, pg_cyc;
  integer      seed;

  // Wire level: device drives while enabled, otherwise the programmer
  assign link_w = oe ? d_o : hdat;

  pfm_sequencer dut (.clk_i(clk_i), .reset_i(reset_i), .ce_i(ce), .prog_clk_i(pclk),
    .prog_data_i(link_w), .prog_data_o(d_o), .prog_data_oe_o(oe), .flash_erase_o(er),
    .flash_program_o(pg), .flash_addr_o(faddr), .flash_done_i(done), .flash_word_idx_i(widx),
    .flash_word_o(fword), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
    .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(rdat), .wb_ack_o(ack));

  pfm_prog_model prog (.clk_i(clk_i), .link_i(link_w), .prog_clk_o(pclk), .prog_data_o(hdat));

  // 100 ns system clock
  initial begin
    clk_i = 1'b0;
    forever #50 clk_i = ~clk_i;
  end

  // Records erase pulses and programming pulse width
  always @(posedge clk_i) begin
    if (er === 1'b1) begin
      er_n <= er_n + 1;
      er_bit <= prog.bit_n;
      er_addr <= faddr;
    end
    if (pg === 1'b1 && pg_cyc == 0) pg_addr <= faddr;
    if (pg === 1'b1) pg_cyc <= pg_cyc + 1;
  end

  task automatic close_out();
    $display("mismatches %0d compares %0d", bad_count, compares);
    if (bad_count == 0 && compares > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : close_out

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    compares++;
    if (g !== e) begin
      bad_count++;
      $display("wrong value at %0t: got %h want %h", $time, g, e);
    end
  endtask : chk

  // Expected memory control byte from its named bits
  function automatic logic [31:0] ctl_exp(input logic pm, input logic row, input logic arm, input logic ws);
    ctl_exp = '0;
    ctl_exp[PFM_PMEM_SEL]    = pm;
    ctl_exp[PFM_ROW_ERASE]   = row;
    ctl_exp[PFM_WRITE_ARM]   = arm;
    ctl_exp[PFM_WRITE_START] = ws;
  endfunction : ctl_exp

  // Classic single Wishbone cycle; waits for ack with a bound
  task automatic wb(input logic w, input logic [3:0] ad, input logic [31:0] dw);
    int n;
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    sel <= 4'hf;
    adr <= ad;
    dat <= dw;
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (ack !== 1'b1 && n < 50);
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    if (n >= 50) chk(32'h0, 32'h1);
  endtask : wb

  task automatic core(input logic [15:0] p);
    prog.word(PFM_CMD_CORE, p, 0, rd);
  endtask : core

  // Pointer load through three literal and move pairs
  task automatic ld_ptr(input logic [21:0] v);
    core({8'h0e, 2'b00, v[21:16]});
    core(16'h6ef8);
    core({8'h0e, v[15:8]});
    core(16'h6ef7);
    core({8'h0e, v[7:0]});
    core(16'h6ef6);
  endtask : ld_ptr

  // Main sequence
  initial begin
    seed = 32'h1c542757;
    {reset_i, ce, cyc, stb, we, done} = 6'b110000;
    {adr, sel, dat, widx, bad_count, compares, er_n, pg_cyc, er_bit} = '0;
    sel = 4'hf;
    repeat (20) @(posedge clk_i);
    reset_i <= 1'b0;
    @(posedge clk_i);
    chk({er, pg, oe, faddr}, 32'h0);
    chk(fword, PFM_BUF_RESET);
    // Reset values, unmapped address 2 last
    foreach (ex[k]) ex[k] = PFM_BUF_RESET;
    for (int k = 0; k < 5; k++) begin
      wb(1'b0, (k == 4) ? 4'h2 : 4'(k * 4), 32'h0);
      chk(q, 32'h0);
    end
    // Link ignored until enabled
    core(16'h0e55);
    core(16'h6ef6);
    wb(1'b0, PFM_REG_POINTER, 32'h0);
    chk(q, 32'h0);
    wb(1'b1, PFM_REG_CTRL, 32'h1);
    wb(1'b0, PFM_REG_CTRL, 32'h0);
    chk(q, 32'h1);
    core(16'h8ea6);
    core(16'h9ca6);
    wb(1'b0, PFM_REG_STATUS, 32'h0);
    chk(q & 32'hff, ctl_exp(1'b1, 1'b0, 1'b0, 1'b0));
    // Write-start without arm must not erase
    core(16'h88a6);
    core(16'h82a6);
    core(16'h0000);
    core(16'h0000);
    wb(1'b0, PFM_REG_STATUS, 32'h0);
    chk(er_n, 0);
    chk(q & 32'hff, ctl_exp(1'b1, 1'b1, 1'b0, 1'b0));
    a = 22'($random(seed)) & 22'h3fffc0;
    ld_ptr(a);
    wb(1'b0, PFM_REG_POINTER, 32'h0);
    chk(q, 32'(a));
    chk(faddr, a);
    // Armed row erase
    core(16'h84a6);
    core(16'h82a6);
    core(16'h0000);
    chk(er_n, 0);
    core(16'h0000);
    chk(er_n, 1);
    chk(er_bit, 4);
    chk(er_addr, a);
    wb(1'b0, PFM_REG_STATUS, 32'h0);
    chk(q & 32'h202, 32'h202);
    // Completion arriving while frozen must be lost
    ce <= 1'b0;
    done <= 1'b1;
    @(posedge clk_i);
    done <= 1'b0;
    repeat (2) @(posedge clk_i);
    ce <= 1'b1;
    wb(1'b0, PFM_REG_STATUS, 32'h0);
    chk(q & 32'h202, 32'h202);
    @(posedge clk_i);
    done <= 1'b1;
    @(posedge clk_i);
    done <= 1'b0;
    core(16'h50a6);
    core(16'h6ef5);
    core(16'h0000);
    prog.word(PFM_CMD_SHOUT, 16'h0000, 0, rd);
    chk(rd, ctl_exp(1'b1, 1'b1, 1'b1, 1'b0));
    core(16'h98a6);
    // Two write buffers rewrite the first part of the erased block
    for (int j = 0; j < 2; j++) begin
      b = a + 22'(16 * j);
      ld_ptr(b);
      for (int k = 0; k < 8; k++) begin
        d = 16'($random(seed));
        ex[k] = d;
        prog.word((k == 7) ? PFM_CMD_TW_GO : PFM_CMD_TW_INC, d, 0, rd);
      end
      wb(1'b0, PFM_REG_POINTER, 32'h0);
      chk(q, 32'(b + 22'd14));
      wb(1'b0, PFM_REG_STATUS, 32'h0);
      chk(q[PFM_ST_PEND], 1'b1);
      pg_cyc = 0;
      prog.word(PFM_CMD_CORE, 16'h0000, 40, rd);
      chk(32'(pg_cyc >= 39 && pg_cyc <= 41), 32'h1);
      chk(pg_addr, b + 22'd14);
      wb(1'b0, PFM_REG_STATUS, 32'h0);
      chk(q[PFM_ST_PEND], 1'b0);
      for (int k = 0; k < 8; k++) begin
        widx <= 3'(k);
        repeat (2) @(posedge clk_i);
        chk(fword, ex[k]);
      end
    end
    core(16'h94a6);
    wb(1'b0, PFM_REG_STATUS, 32'h0);
    chk(q & 32'hff, ctl_exp(1'b1, 1'b0, 1'b0, 1'b0));
    close_out();
  end

  // Watchdog well beyond the roughly ten thousand cycles needed
  initial begin
    repeat (40000) @(posedge clk_i);
    bad_count++;
    close_out();
  end
endmodule : tb_pfm_sequencer
